// ==== hdl/sac_params.svh ====
// Purpose: Register map, field positions, reset values and timing figures.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Definitions only.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// Byte offsets.
`define SAC_OFS_CTRL    8'h00
`define SAC_OFS_CFG     8'h04
`define SAC_OFS_RESLO   8'h08
`define SAC_OFS_RESHI   8'h0c
`define SAC_OFS_WINLO   8'h10
`define SAC_OFS_WINHI   8'h14
`define SAC_OFS_STATUS  8'h18
`define SAC_OFS_IRQEN   8'h1c
`define SAC_OFS_IRQCLR  8'h20

// Control fields.
`define SAC_CTRL_EN     0
`define SAC_CTRL_SRC_LO 1
`define SAC_CTRL_SW     3
`define SAC_CTRL_LJUST  4

// Configuration fields.
`define SAC_CFG_CH_LO   0
`define SAC_CFG_GAIN_LO 4
`define SAC_CFG_DIFF_LO 8

// Status, enable and clear fields.
`define SAC_ST_DONE     0
`define SAC_ST_WIN      1
`define SAC_ST_BUSY     2
`define SAC_ST_HALT     3

// Reset values.
`define SAC_RST_CH      4'h0
`define SAC_RST_GAIN    3'h1
`define SAC_RST_WINLO   16'h0000
`define SAC_RST_WINHI   16'hffff

// Encoding limits.
`define SAC_GAIN_MAX    3'h5
`define SAC_CH_TEMP     4'h8

// Timing in nanoseconds.
`define SAC_CLK_NS      5
`define SAC_TRACK_NS    1500
`define SAC_BIT_NS      500
`define SAC_CONV_NS     10000

`endif

// ==== hdl/sac_pkg.sv ====
// Purpose: Types shared by the conversion control block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in sac_params.svh.
package sac_pkg;

	typedef enum logic [1:0] {
		SRC_SW,
		SRC_TMR2,
		SRC_TMR3,
		SRC_EXT
	} sac_src_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TRACK,
		ST_CONVERT
	} sac_state_t;

endpackage

// ==== hdl/sac_conv_ctrl.sv ====
// Purpose: Conversion control for a successive-approximation converter.
// Assumes: All inputs synchronous to clock; analog macro outside.
// Notes:   APB slave, one wait-free access cycle per transfer.
// How it works
// - Start from software, second timer overflow, third timer, or pin.
// - Each completion raises the done flag and an interrupt request.
// - Completed result is latched into two byte-wide result registers.
// - Software picks right or left alignment of the stored result.
// - Window event fires only when the result lies inside bounds.
// - Gain after the multiplexer from one half to sixteen.
// - Nine inputs: eight external channels plus temperature sensor.
// - Each adjacent external pair is single-ended or differential.
// - Software can shut the converter down to save power.
// - Sequencing allows back-to-back conversions at 100k per second.
// - Result width is a build parameter, twelve or ten bits.
// - Converter keeps running while the processor is halted.
`timescale 1ns/1ps
`include "sac_params.svh"

module sac_conv_ctrl #(
	parameter int RES = 12
) (
	// Clock, reset and clock enable.
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        clkEn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Start sources and debug state.
	input  wire logic        tmr2Ovf,
	input  wire logic        tmr3Ovf,
	input  wire logic        extStart,
	input  wire logic        dbgHalt,
	// Analog macro.
	input  wire logic        anaCompare,
	output logic [3:0]       anaChannel,
	output logic             anaDiff,
	output logic [2:0]       anaGain,
	output logic             anaPowerDown,
	output logic             anaTrack,
	output logic [RES-1:0]   sarTrial,
	// Interrupt.
	output logic             irq
);

	localparam int TRACK_CYC = (`SAC_TRACK_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS;
	localparam int BIT_CYC   = (`SAC_BIT_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS;
	localparam int CONV_CYC  = `SAC_CONV_NS / `SAC_CLK_NS;

	sac_pkg::sac_state_t state_ff;
	sac_pkg::sac_src_t   src_ff;
	logic           enable_ff, leftJust_ff, extPrev_ff;
	logic           pready_ff, pslverr_ff, irq_ff;
	logic           anaDiff_ff, anaPowerDown_ff, anaTrack_ff;
	logic [3:0]     cfgCh_ff, cfgDiff_ff, stat_ff, anaChannel_ff;
	logic [2:0]     cfgGain_ff, anaGain_ff;
	logic [15:0]    winLo_ff, winHi_ff;
	logic [7:0]     resLo_ff, resHi_ff;
	logic [1:0]     irqEn_ff;
	logic [11:0]    cnt_ff;
	logic [31:0]    prdata_ff;
	logic [RES-1:0] resRaw_ff, mask_ff, trial_ff;
	logic           apbWr, swGo, startPulse;
	logic           convDone, inWindow, nxt_slverr;
	logic [RES-1:0] finalCode;
	logic [15:0]    justified;
	logic [1:0]     evtSet, evtClr;
	logic [31:0]    nxt_prdata;

	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign irq          = irq_ff;
	assign anaChannel   = anaChannel_ff;
	assign anaDiff      = anaDiff_ff;
	assign anaGain      = anaGain_ff;
	assign anaPowerDown = anaPowerDown_ff;
	assign anaTrack     = anaTrack_ff;
	assign sarTrial     = trial_ff;

	// A write lands at the access edge, which is the only edge with pready.
	assign apbWr = clkEn && psel && penable && pwrite && pready_ff;
	assign swGo  = apbWr && (paddr == `SAC_OFS_CTRL) && pwdata[`SAC_CTRL_SW];

	always_comb begin
		case (src_ff)
			sac_pkg::SRC_SW:   startPulse = swGo;
			sac_pkg::SRC_TMR2: startPulse = tmr2Ovf;
			sac_pkg::SRC_TMR3: startPulse = tmr3Ovf;
			sac_pkg::SRC_EXT:  startPulse = extStart && !extPrev_ff;
			default:           startPulse = 1'b0;
		endcase
	end

	assign convDone  = (state_ff == sac_pkg::ST_CONVERT) && (cnt_ff == 12'h000)
		&& mask_ff[0];
	assign finalCode = anaCompare ? trial_ff : (trial_ff & ~mask_ff);
	// Left alignment moves the code to the top of the sixteen-bit pair.
	assign justified = leftJust_ff ? 16'({finalCode, (16 - RES)'(0)})
		: 16'(finalCode);
	assign inWindow  = (16'(finalCode) >= winLo_ff)
		&& (16'(finalCode) <= winHi_ff);

	// Control and configuration registers; out-of-range channel codes are clamped, out-of-range gain codes revert to the reset gain.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			enable_ff   <= 1'b0;
			src_ff      <= sac_pkg::SRC_SW;
			leftJust_ff <= 1'b0;
			cfgCh_ff    <= `SAC_RST_CH;
			cfgGain_ff  <= `SAC_RST_GAIN;
			cfgDiff_ff  <= 4'h0;
			winLo_ff    <= `SAC_RST_WINLO;
			winHi_ff    <= `SAC_RST_WINHI;
			irqEn_ff    <= 2'h0;
		end else if (apbWr) begin
			case (paddr)
				`SAC_OFS_CTRL: begin
					enable_ff   <= pwdata[`SAC_CTRL_EN];
					src_ff      <= sac_pkg::sac_src_t'(
						pwdata[`SAC_CTRL_SRC_LO +: 2]);
					leftJust_ff <= pwdata[`SAC_CTRL_LJUST];
				end
				`SAC_OFS_CFG: begin
					cfgCh_ff <= (pwdata[`SAC_CFG_CH_LO +: 4] > `SAC_CH_TEMP)
						? `SAC_CH_TEMP : pwdata[`SAC_CFG_CH_LO +: 4];
					cfgGain_ff <= (pwdata[`SAC_CFG_GAIN_LO +: 3] > `SAC_GAIN_MAX)
						? `SAC_RST_GAIN : pwdata[`SAC_CFG_GAIN_LO +: 3];
					cfgDiff_ff <= pwdata[`SAC_CFG_DIFF_LO +: 4];
				end
				`SAC_OFS_WINLO: winLo_ff <= pwdata[15:0];
				`SAC_OFS_WINHI: winHi_ff <= pwdata[15:0];
				`SAC_OFS_IRQEN: irqEn_ff <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Routing to the analog macro; a differential pair uses its even input.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			anaChannel_ff   <= `SAC_RST_CH;
			anaDiff_ff      <= 1'b0;
			anaGain_ff      <= `SAC_RST_GAIN;
			anaPowerDown_ff <= 1'b1;
		end else if (clkEn) begin
			anaDiff_ff    <= !cfgCh_ff[3] && cfgDiff_ff[cfgCh_ff[2:1]];
			anaChannel_ff <= (!cfgCh_ff[3] && cfgDiff_ff[cfgCh_ff[2:1]])
				? {cfgCh_ff[3:1], 1'b0} : cfgCh_ff;
			anaGain_ff      <= cfgGain_ff;
			anaPowerDown_ff <= !enable_ff;
		end
	end

	// Sequencer. The debug halt input is deliberately not consulted here,
	// so a halted processor never stalls a conversion in flight.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_ff    <= sac_pkg::ST_IDLE;
			cnt_ff      <= 12'h000;
			mask_ff     <= '0;
			trial_ff    <= '0;
			anaTrack_ff <= 1'b0;
			extPrev_ff  <= 1'b0;
		end else if (clkEn) begin
			extPrev_ff <= extStart;
			if (!enable_ff) begin
				state_ff    <= sac_pkg::ST_IDLE;
				anaTrack_ff <= 1'b0;
			end else begin
				case (state_ff)
					sac_pkg::ST_IDLE: begin
						if (startPulse) begin
							state_ff    <= sac_pkg::ST_TRACK;
							cnt_ff      <= 12'(TRACK_CYC - 1);
							anaTrack_ff <= 1'b1;
						end
					end
					sac_pkg::ST_TRACK: begin
						if (cnt_ff == 12'h000) begin
							state_ff    <= sac_pkg::ST_CONVERT;
							cnt_ff      <= 12'(BIT_CYC - 1);
							mask_ff     <= {1'b1, (RES - 1)'(0)};
							trial_ff    <= {1'b1, (RES - 1)'(0)};
							anaTrack_ff <= 1'b0;
						end else begin
							cnt_ff <= cnt_ff - 12'h001;
						end
					end
					sac_pkg::ST_CONVERT: begin
						// Triggers are simply not looked at here.
						if (cnt_ff != 12'h000) begin
							cnt_ff <= cnt_ff - 12'h001;
						end else if (mask_ff[0]) begin
							trial_ff <= finalCode;
							state_ff <= sac_pkg::ST_IDLE;
						end else begin
							trial_ff <= finalCode | (mask_ff >> 1);
							mask_ff  <= mask_ff >> 1;
							cnt_ff   <= 12'(BIT_CYC - 1);
						end
					end
					default: state_ff <= sac_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// Result latch.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			resRaw_ff <= '0;
			resLo_ff  <= 8'h00;
			resHi_ff  <= 8'h00;
		end else if (clkEn && convDone) begin
			resRaw_ff <= finalCode;
			resLo_ff  <= justified[7:0];
			resHi_ff  <= justified[15:8];
		end
	end

	// Sticky event flags; a set in the clearing cycle wins.
	assign evtSet = {convDone && inWindow, convDone};
	assign evtClr = (apbWr && paddr == `SAC_OFS_IRQCLR) ? pwdata[1:0] : 2'h0;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gSticky
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					stat_ff[g] <= 1'b0;
				end else if (clkEn) begin
					stat_ff[g] <= evtSet[g] || (stat_ff[g] && !evtClr[g]);
				end
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stat_ff[3:2] <= 2'h0;
			irq_ff       <= 1'b0;
		end else if (clkEn) begin
			stat_ff[`SAC_ST_BUSY] <= (state_ff != sac_pkg::ST_IDLE);
			stat_ff[`SAC_ST_HALT] <= dbgHalt;
			irq_ff <= |(stat_ff[1:0] & irqEn_ff);
		end
	end

	// Read data is captured in the setup cycle and shown during access.
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_slverr = 1'b0;
		case (paddr)
			`SAC_OFS_CTRL: begin
				nxt_prdata[`SAC_CTRL_EN]           = enable_ff;
				nxt_prdata[`SAC_CTRL_SRC_LO +: 2]  = src_ff;
				nxt_prdata[`SAC_CTRL_LJUST]        = leftJust_ff;
			end
			`SAC_OFS_CFG: begin
				nxt_prdata[`SAC_CFG_CH_LO +: 4]   = cfgCh_ff;
				nxt_prdata[`SAC_CFG_GAIN_LO +: 3] = cfgGain_ff;
				nxt_prdata[`SAC_CFG_DIFF_LO +: 4] = cfgDiff_ff;
			end
			`SAC_OFS_RESLO:  nxt_prdata[7:0]  = resLo_ff;
			`SAC_OFS_RESHI:  nxt_prdata[7:0]  = resHi_ff;
			`SAC_OFS_WINLO:  nxt_prdata[15:0] = winLo_ff;
			`SAC_OFS_WINHI:  nxt_prdata[15:0] = winHi_ff;
			`SAC_OFS_STATUS: nxt_prdata[3:0]  = stat_ff;
			`SAC_OFS_IRQEN:  nxt_prdata[1:0]  = irqEn_ff;
			`SAC_OFS_IRQCLR: nxt_prdata       = 32'h0000_0000;
			default:         nxt_slverr       = 1'b1;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else if (clkEn) begin
			pready_ff  <= psel && !penable && !pready_ff;
			pslverr_ff <= psel && !penable && !pready_ff && nxt_slverr;
			if (psel && !penable && !pready_ff && !pwrite) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	// Cycles from an accepted start to completion, for the rate check.
	logic [11:0] convLen_ff;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			convLen_ff <= 12'h000;
		end else if (clkEn) begin
			if (state_ff == sac_pkg::ST_IDLE) begin
				convLen_ff <= 12'h001;
			end else if (convLen_ff != 12'hfff) begin
				convLen_ff <= convLen_ff + 12'h001;
			end
		end
	end

	a_start_accepted: assert property (@(posedge clock) disable iff (sys_rst)
		clkEn && enable_ff && state_ff == sac_pkg::ST_IDLE && startPulse
		|=> state_ff == sac_pkg::ST_TRACK && anaTrack_ff)
		else $error("Accepted start did not begin tracking.");

	a_done_flag_set: assert property (@(posedge clock) disable iff (sys_rst)
		clkEn && convDone |=> stat_ff[`SAC_ST_DONE]
		##1 (!$past(clkEn) || !$past(irqEn_ff[0]) || irq_ff))
		else $error("Completion did not set done flag or interrupt.");

	a_result_latch: assert property (@(posedge clock) disable iff (sys_rst)
		clkEn && convDone |=> resRaw_ff == $past(finalCode))
		else $error("Result word not latched at completion.");

	a_left_justify: assert property (@(posedge clock) disable iff (sys_rst)
		clkEn && convDone && leftJust_ff
		|=> {resHi_ff, resLo_ff} == 16'(resRaw_ff) << (16 - RES))
		else $error("Left-aligned result misplaced.");

	a_window_inside: assert property (@(posedge clock) disable iff (sys_rst)
		clkEn && !stat_ff[`SAC_ST_WIN] && !(convDone && inWindow)
		|=> !stat_ff[`SAC_ST_WIN])
		else $error("Window flag set for a result outside bounds.");

	a_gain_range: assert property (@(posedge clock) disable iff (sys_rst)
		anaGain_ff <= `SAC_GAIN_MAX)
		else $error("Gain code out of range.");

	a_diff_pair: assert property (@(posedge clock) disable iff (sys_rst)
		anaDiff_ff |-> !anaChannel_ff[0] && anaChannel_ff < `SAC_CH_TEMP)
		else $error("Differential route not on an even external input.");

	a_channel_range: assert property (@(posedge clock) disable iff (sys_rst)
		anaChannel_ff <= `SAC_CH_TEMP)
		else $error("Channel selection beyond temperature sensor.");

	a_shutdown_idle: assert property (@(posedge clock) disable iff (sys_rst)
		anaPowerDown_ff |-> state_ff == sac_pkg::ST_IDLE)
		else $error("Converter active while shut down.");

	a_conv_rate: assert property (@(posedge clock) disable iff (sys_rst)
		convDone |-> convLen_ff < 12'(CONV_CYC))
		else $error("Conversion too long for full rate.");

	a_halt_runs: assert property (@(posedge clock) disable iff (sys_rst)
		clkEn && dbgHalt && state_ff != sac_pkg::ST_IDLE && cnt_ff != 12'h000
		&& enable_ff |=> cnt_ff == $past(cnt_ff) - 12'h001)
		else $error("Conversion stalled during processor halt.");

	a_busy_ignores: assert property (@(posedge clock) disable iff (sys_rst)
		clkEn && state_ff == sac_pkg::ST_CONVERT && startPulse
		|=> state_ff != sac_pkg::ST_TRACK)
		else $error("Start during conversion restarted it.");

endmodule

// ==== bench/test_sar_adc_conversion_control.sv ====
// Purpose: Self-checking bench for the conversion control block.
// Assumes: Design built with RES=12; comparator modelled from sarTrial.
// Notes:   Register reads are checked by a monitor against a queue.
`timescale 1ns/1ps
`include "sac_params.svh"

module test_sar_adc_conversion_control;
	logic        clock, sys_rst, clkEn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, cv;
	logic        pready, pslverr, tmr2Ovf, tmr3Ovf, extStart, dbgHalt;
	logic        anaCompare, anaDiff, anaPowerDown, anaTrack, irq;
	logic [3:0]  anaChannel;
	logic [2:0]  anaGain;
	logic [11:0] sarTrial, tgt;
	logic [15:0] r16;
	logic [32:0] expQ[$];
	logic [31:0] rs = 32'h7f8663fd;
	int          miscompares = 0;
	int          cmpCount = 0;
	int          n;

	sac_conv_ctrl #(.RES(12)) dut_u (
		.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tmr2Ovf(tmr2Ovf), .tmr3Ovf(tmr3Ovf),
		.extStart(extStart), .dbgHalt(dbgHalt), .anaCompare(anaCompare),
		.anaChannel(anaChannel), .anaDiff(anaDiff), .anaGain(anaGain),
		.anaPowerDown(anaPowerDown), .anaTrack(anaTrack),
		.sarTrial(sarTrial), .irq(irq)
	);

	always #2.5 clock = ~clock;

	// The comparator lags one cycle; harmless, as each bit lasts 100 cycles.
	always @(posedge clock)
		anaCompare <= (sarTrial <= tgt);

	always @(posedge clock)
		if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
			chk({pslverr, prdata}, expQ.pop_front());

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [32:0] s, input logic [32:0] e);
		cmpCount++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask

	task automatic end_of_test;
		$display("miscompares %0d compares %0d", miscompares, cmpCount);
		if (miscompares == 0 && cmpCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask

	// An idle edge follows each transfer so no signal is driven twice at once.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic trig(input int s);
		case (s)
			0: wr(`SAC_OFS_CTRL, cv | 32'h8);
			1: tmr2Ovf <= 1'b1;
			2: tmr3Ovf <= 1'b1;
			default: extStart <= 1'b1;
		endcase
		@(posedge clock);
		{tmr2Ovf, tmr3Ovf, extStart} <= 3'b000;
		@(posedge clock);
	endtask

	initial begin
		cyc(40000);
		miscompares++;
		end_of_test;
	end

	initial begin
		{clock, psel, penable, pwrite, tmr2Ovf, tmr3Ovf} = '0;
		{extStart, dbgHalt, paddr, pwdata, tgt} = '0;
		sys_rst = 1'b1;
		clkEn = 1'b1;
		cv = 32'h0;
		cyc(12);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(`SAC_OFS_CFG, 33'h10);
		rd(`SAC_OFS_WINLO, 33'h0);
		rd(`SAC_OFS_WINHI, 33'hffff);
		rd(`SAC_OFS_STATUS, 33'h0);
		rd(`SAC_OFS_IRQCLR, 33'h0);
		rd(8'h24, {1'b1, 32'h0});
		chk(33'(anaPowerDown), 33'h1);
		for (int i = 0; i < 9; i++) begin
			wr(`SAC_OFS_CFG, 32'(i) | 32'(i % 6) << 4);
			cyc(2);
			chk(33'({anaChannel, anaGain}), 33'({4'(i), 3'(i % 6)}));
		end
		wr(`SAC_OFS_CFG, 32'h27f);
		cyc(2);
		chk(33'({anaChannel, anaGain, anaDiff}), 33'h82);
		rd(`SAC_OFS_CFG, 33'h218);
		wr(`SAC_OFS_CFG, 32'h253);
		cyc(2);
		chk(33'({anaChannel, anaGain, anaDiff}), 33'h2b);
		wr(`SAC_OFS_IRQEN, 32'h3);
		cv = 32'h1;
		wr(`SAC_OFS_CTRL, cv);
		cyc(2);
		chk(33'(anaPowerDown), 33'h0);
		for (int s = 0; s < 4; s++) begin
			rs = lfsr(rs);
			tgt = rs[11:0];
			dbgHalt <= (s == 2);
			cv = 32'(s[0]) << 4 | 32'(s) << 1 | 32'h1;
			wr(`SAC_OFS_WINLO, 32'(tgt) + 32'(s[0]));
			wr(`SAC_OFS_WINHI, s[0] ? 32'hffff : 32'(tgt));
			wr(`SAC_OFS_CTRL, cv);
			trig(s);
			chk(33'(anaTrack), 33'h1);
			cyc(800);
			trig(s);
			chk(33'(anaTrack), 33'h0);
			rd(`SAC_OFS_STATUS, 33'({(s == 2), 3'b100}));
			n = 0;
			while (irq !== 1'b1 && n < 3000) begin
				@(posedge clock);
				n++;
			end
			chk(33'(n > 600 && n < 800), 33'h1);
			r16 = s[0] ? {tgt, 4'h0} : {4'h0, tgt};
			rd(`SAC_OFS_RESLO, {25'h0, r16[7:0]});
			rd(`SAC_OFS_RESHI, {25'h0, r16[15:8]});
			rd(`SAC_OFS_STATUS, 33'({(s == 2), 1'b0, !s[0], 1'b1}));
			wr(`SAC_OFS_IRQCLR, 32'h3);
			cyc(2);
			chk(33'(irq), 33'h0);
		end
		dbgHalt <= 1'b0;
		wr(`SAC_OFS_WINLO, 32'hffff);
		wr(`SAC_OFS_WINHI, 32'h0);
		wr(`SAC_OFS_IRQEN, 32'h0);
		cv = 32'h1;
		wr(`SAC_OFS_CTRL, cv);
		trig(0);
		cyc(500);
		clkEn <= 1'b0;
		cyc(1);
		r16 = 16'(sarTrial);
		cyc(100);
		chk(33'(sarTrial), 33'(r16));
		clkEn <= 1'b1;
		cyc(1100);
		chk(33'(irq), 33'h0);
		rd(`SAC_OFS_STATUS, 33'h1);
		wr(`SAC_OFS_IRQEN, 32'h1);
		cyc(2);
		chk(33'(irq), 33'h1);
		wr(`SAC_OFS_CTRL, 32'h0);
		cyc(2);
		chk(33'(anaPowerDown), 33'h1);
		end_of_test;
	end
endmodule
